// ---- omc_pkg.sv ----
// omc_pkg: constants and types for the optical module control/status block.
// assumes a single 100 MHz clock domain.
package omc_pkg;
   // =====================================================
   // clock and timing
   // =====================================================
   localparam int CLK_MHZ          = 100;
   localparam int T_OFF_US         = 10;
   localparam int T_ON_US          = 1000;
   localparam int T_INIT_MS        = 300;
   localparam int T_FAULT_US       = 100;
   localparam int T_RESET_US       = 10;
   localparam int T_LOSS_US        = 100;
   localparam int SER_CLK_KHZ      = 100;
   localparam int OFF_CYC          = T_OFF_US * CLK_MHZ;
   localparam int ON_CYC           = T_ON_US * CLK_MHZ;
   localparam int INIT_CYC         = T_INIT_MS * 1000 * CLK_MHZ;
   localparam int FAULT_CYC        = T_FAULT_US * CLK_MHZ;
   localparam int RESET_HOLD_CYC   = T_RESET_US * CLK_MHZ;
   localparam int LOSS_CYC         = T_LOSS_US * CLK_MHZ;
   localparam int SER_MIN_CYC      = (CLK_MHZ * 1000) / SER_CLK_KHZ;
   // internal start-up delay before the laser may turn on
   localparam int LASER_ON_CYC     = 1000;
   localparam int HOLD_W           = 12;
   // pin idle levels {id clock, above, below, fault, off request}
   localparam logic [4:0] PIN_RESET_VAL = 5'h15;

   typedef enum logic [1:0] {
      OMC_INIT  = 2'b00,
      OMC_OFF   = 2'b01,
      OMC_ON    = 2'b10,
      OMC_FAULT = 2'b11
   } omc_state_type;
endpackage

// ---- omc_sync_if.sv ----
// omc_sync_if: synchronised pin levels passed from the input stage to the core.
// assumes one clock domain.
`timescale 1ns/1ps
interface omc_sync_if;
   logic laser_off;
   logic laser_fault;
   logic light_low;
   logic light_ok;
   modport src (output laser_off, output laser_fault, output light_low, output light_ok);
   modport dst (input laser_off, input laser_fault, input light_low, input light_ok);
endinterface

// ---- omc_sync.sv ----
// omc_sync: three-stage pin synchronisers; a change is taken once stages 2 and 3 agree.
// assumes asynchronous pins and an active clock enable.
`timescale 1ns/1ps
module omc_sync #(
   parameter int N = 4
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         clk_en,
   input  wire logic [N-1:0] pins,
   input  wire logic [N-1:0] reset_val,
   output      logic [N-1:0] level
);
   logic [N-1:0] s1_r;
   logic [N-1:0] s2_r;
   logic [N-1:0] s3_r;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s1_r <= reset_val;
         s2_r <= reset_val;
         s3_r <= reset_val;
      end else if (clk_en) begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // level follows only when stages agree, filtering one-cycle glitches
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         level <= reset_val;
      end else if (clk_en) begin
         for (int i = 0; i < N; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               level[i] <= s3_r[i];
            end
         end
      end
   end
endmodule

// ---- omc_ctrl.sv ----
// omc_ctrl: laser enable, latched transmitter fault and light-loss flag supervisor.
// assumes rst_n is the power-on reset and the inputs come from pins.
`timescale 1ns/1ps
// Functional notes
// - laser output returns within 1 ms of the off request falling.
// - initialisation and fault clear finish within 300 ms.
// - fault flag rises within 100 us of a laser fault.
// - light-loss flag rises within 100 us of lost light.
// - light-loss flag falls within 100 us of light returning.
// - flag falls when comparator reports power above assert level.
// - flag rises when comparator reports power below deassert level; hysteresis kept.
// - fault flag is one exactly while laser shutdown is active.
// - low off request enables laser; high or open keeps it off.
module omc_ctrl
   import omc_pkg::*;
#(
   parameter int INIT_CYCLES = INIT_CYC
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic clk_en,
   input  wire logic laser_off_req,
   input  wire logic laser_fault_det,
   input  wire logic rx_below_deassert,
   input  wire logic rx_above_assert,
   input  wire logic id_clk_pin,
   output      logic laser_en,
   output      logic tx_fault_flag,
   output      logic light_loss_flag,
   output      logic id_clk_too_fast
);
   // =====================================================
   // input synchronisation
   // =====================================================
   omc_sync_if sif ();
   logic [4:0] lvl;

   // stages start at the pins' idle levels: off request high (open pin keeps
   // the laser dark), fault low, id clock high; any other value latches a
   // false fault or a false id clock edge on the first edges after reset
   omc_sync #(.N(5)) u_sync (
      .clock     (clock),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .pins      ({id_clk_pin, rx_above_assert, rx_below_deassert,
                   laser_fault_det, laser_off_req}),
      .reset_val (PIN_RESET_VAL),
      .level     (lvl)
   );
   assign sif.laser_off   = lvl[0];
   assign sif.laser_fault = lvl[1];
   assign sif.light_low   = lvl[2];
   assign sif.light_ok    = lvl[3];

   // =====================================================
   // transmit state machine
   // =====================================================
   omc_state_type state_r;
   omc_state_type state_nxt;
   logic [31:0]   init_cnt_r;
   logic [HOLD_W-1:0] hold_cnt_r;
   logic          hold_ok;
   logic          off_q_r;

   assign hold_ok = (hold_cnt_r >= HOLD_W'(RESET_HOLD_CYC));

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         OMC_INIT:  if (sif.laser_fault) state_nxt = OMC_FAULT;
                    else if (init_cnt_r >= 32'(LASER_ON_CYC))
                       state_nxt = sif.laser_off ? OMC_OFF : OMC_ON;
         OMC_OFF:   if (sif.laser_fault) state_nxt = OMC_FAULT;
                    else if (!sif.laser_off) state_nxt = OMC_ON;
         OMC_ON:    if (sif.laser_fault) state_nxt = OMC_FAULT;
                    else if (sif.laser_off) state_nxt = OMC_OFF;
         // clear only on falling request after a long enough high
         OMC_FAULT: if (off_q_r && !sif.laser_off && hold_ok)
                       state_nxt = OMC_INIT;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_r <= OMC_INIT;
      end else if (clk_en) begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         init_cnt_r <= '0;
      end else if (clk_en) begin
         // the cap only stops the counter wrapping; the start delay ends init
         if (state_r != OMC_INIT) init_cnt_r <= '0;
         else if (init_cnt_r < 32'(INIT_CYCLES)) init_cnt_r <= init_cnt_r + 32'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         hold_cnt_r <= '0;
         off_q_r    <= 1'b1;
      end else if (clk_en) begin
         off_q_r <= sif.laser_off;
         // counts only while the synchronised request is high; saturates
         if (!sif.laser_off) hold_cnt_r <= '0;
         else if (!hold_ok) hold_cnt_r <= hold_cnt_r + HOLD_W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         laser_en      <= 1'b0;
         tx_fault_flag <= 1'b0;
      end else if (clk_en) begin
         laser_en      <= (state_nxt == OMC_ON);
         tx_fault_flag <= (state_nxt == OMC_FAULT);
      end
   end

   // =====================================================
   // light-loss flag with comparator hysteresis
   // =====================================================
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         light_loss_flag <= 1'b1;
      end else if (clk_en) begin
         if (sif.light_ok) light_loss_flag <= 1'b0;
         else if (sif.light_low) light_loss_flag <= 1'b1;
      end
   end

   // =====================================================
   // identification clock rate monitor
   // =====================================================
   logic [HOLD_W-1:0] per_cnt_r;
   logic              idc_q_r;
   logic              idc_rise;

   assign idc_rise = lvl[4] && !idc_q_r;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         per_cnt_r       <= '0;
         // idle clock stands high: a low start would fake an edge after reset
         idc_q_r         <= 1'b1;
         id_clk_too_fast <= 1'b0;
      end else if (clk_en) begin
         idc_q_r <= lvl[4];
         if (idc_rise) begin
            // flags a host violating the link rate; informational only
            id_clk_too_fast <= (per_cnt_r < HOLD_W'(SER_MIN_CYC));
            // start at one so the count at the next edge equals the period
            per_cnt_r       <= HOLD_W'(1);
         end else if (per_cnt_r < HOLD_W'(SER_MIN_CYC)) begin
            per_cnt_r <= per_cnt_r + HOLD_W'(1);
         end
      end
   end

   // =====================================================
   // checks
   // =====================================================
   a_fault_shut_laser: assert property (@(posedge clock) disable iff (!rst_n)
      tx_fault_flag |-> !laser_en) else $error("laser on while fault flag set");
   a_fault_latch: assert property (@(posedge clock) disable iff (!rst_n)
      tx_fault_flag && clk_en && sif.laser_off |=> tx_fault_flag)
      else $error("fault flag lost while off request high");
   a_fault_assert: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && sif.laser_fault && state_r != OMC_FAULT |=> tx_fault_flag)
      else $error("fault flag late");
   a_off_fast: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && sif.laser_off |=> !laser_en) else $error("laser not off");
   a_on_time: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && state_r == OMC_OFF && !sif.laser_off && !sif.laser_fault |=> laser_en)
      else $error("laser not on");
   a_loss_set: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && sif.light_low && !sif.light_ok |=> light_loss_flag)
      else $error("light loss flag not set");
   a_loss_clr: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && sif.light_ok |=> !light_loss_flag) else $error("light loss flag not cleared");
   a_init_bound: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && state_r == OMC_INIT && init_cnt_r >= 32'(LASER_ON_CYC)
      |=> state_r != OMC_INIT) else $error("init did not finish");
   a_on_after_init: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && state_r == OMC_INIT && init_cnt_r >= 32'(LASER_ON_CYC)
      && !sif.laser_off && !sif.laser_fault |=> laser_en)
      else $error("laser not on after init");
   a_fault_clear: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && state_r == OMC_FAULT && off_q_r && !sif.laser_off && hold_ok
      |=> !tx_fault_flag) else $error("fault not cleared");
   // a short off pulse must leave the fault latched
   a_clear_needs_hold: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && state_r == OMC_FAULT && !hold_ok |=> tx_fault_flag)
      else $error("fault cleared without long hold");
   a_laser_state: assert property (@(posedge clock) disable iff (!rst_n)
      laser_en == (state_r == OMC_ON))
      else $error("laser enable out of step");
   a_fault_state: assert property (@(posedge clock) disable iff (!rst_n)
      tx_fault_flag == (state_r == OMC_FAULT))
      else $error("fault flag out of step");
   // clock enable low must freeze the state register and the laser enable
   a_freeze_state: assert property (@(posedge clock) disable iff (!rst_n)
      !clk_en |=> $stable(state_r) && $stable(laser_en))
      else $error("state moved while frozen");

   // =====================================================
   // receive and id link checks
   // =====================================================
   // between the thresholds the flag keeps its state: this is the hysteresis
   a_loss_hold: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && !sif.light_ok && !sif.light_low |=> $stable(light_loss_flag))
      else $error("light loss flag moved between thresholds");
   // the flag follows the period just ended, end point exclusive
   a_idc_slow: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && idc_rise && per_cnt_r >= HOLD_W'(SER_MIN_CYC) |=> !id_clk_too_fast)
      else $error("slow id clock flagged");
   a_idc_fast: assert property (@(posedge clock) disable iff (!rst_n)
      clk_en && idc_rise && per_cnt_r < HOLD_W'(SER_MIN_CYC) |=> id_clk_too_fast)
      else $error("fast id clock not flagged");
endmodule

// ---- omc_host_model.sv ----
// omc_host_model: host board controller driving the off request and id clock.
// assumes bench controls change at the falling edge of clock.
`timescale 1ns/1ps
module omc_host_model
   import omc_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       off_lvl,
   input  wire logic       clear_go,
   input  wire logic [1:0] id_mode,
   output      logic       laser_off_req,
   output      logic       id_clk_pin
);
   int hold_cnt = 0;
   int id_cnt   = 0;
   initial laser_off_req = 1'b1;
   initial id_clk_pin = 1'b1;
   // ==========================================
   // counters on the rising edge, pins on the falling edge
   // ==========================================
   always @(posedge clock) begin
      // margin covers the pin synchroniser delay
      if (clear_go) hold_cnt <= RESET_HOLD_CYC + 20;
      else if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
      // half periods of SER_MIN_CYC/2 cycles put mode 1 exactly on the rate limit
      if (id_mode == 2'h0 || id_cnt == 0) id_cnt <= (id_mode == 2'h2) ? 99 : SER_MIN_CYC / 2 - 1;
      else id_cnt <= id_cnt - 1;
   end
   always @(negedge clock) begin
      laser_off_req <= off_lvl | (hold_cnt != 0);
      // mode 2 is a deliberately fast clock; idle clock stands high
      if (id_mode == 2'h0) id_clk_pin <= 1'b1;
      else if (id_cnt == 0) id_clk_pin <= ~id_clk_pin;
   end
endmodule

// ---- tb.sv ----
// tb: self-checking bench for omc_ctrl with a host model.
// assumes a 100 MHz clock and a shortened init count.
`timescale 1ns/1ps
module tb;
   import omc_pkg::*;
   localparam int INIT_T = 2000;
   // ==========================================
   // clock, design and host
   // ==========================================
   logic        clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, fault = 1'b0;
   logic        below = 1'b0, above = 1'b0, off_lvl = 1'b1, clear_go = 1'b0;
   logic [1:0]  id_mode = 2'h0;
   logic        laser_off_req, id_clk_pin, laser_en, tx_fault_flag;
   logic        light_loss_flag, id_clk_too_fast;
   logic [31:0] rng = 32'h0000769e;
   int          errors = 0, checks = 0;
   always #5 clock = ~clock;
   omc_ctrl #(.INIT_CYCLES(INIT_T)) i_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
      .laser_off_req(laser_off_req), .laser_fault_det(fault), .rx_below_deassert(below),
      .rx_above_assert(above), .id_clk_pin(id_clk_pin), .laser_en(laser_en),
      .tx_fault_flag(tx_fault_flag), .light_loss_flag(light_loss_flag),
      .id_clk_too_fast(id_clk_too_fast));
   omc_host_model i_host (.clock(clock), .off_lvl(off_lvl), .clear_go(clear_go),
      .id_mode(id_mode), .laser_off_req(laser_off_req), .id_clk_pin(id_clk_pin));
   // ==========================================
   // helpers
   // ==========================================
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   // comparator above wins; neither keeps the flag where it was
   function automatic logic exp_loss(logic b, logic a, logic prev);
      return a ? 1'b0 : (b ? 1'b1 : prev);
   endfunction
   function automatic logic pick(int s);
      case (s)
         0: return laser_en;
         1: return tx_fault_flag;
         default: return light_loss_flag;
      endcase
   endfunction
   task automatic check(input logic seen, input logic exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: got %b expected %b", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic wait_for(input int s, input logic v, input int lim);
      int n;
      n = 0;
      while (pick(s) !== v && n < lim) begin
         @(negedge clock);
         n++;
      end
      check(pick(s), v);
      if (pick(s) !== v) end_sim();
   endtask
   // ==========================================
   // scenarios
   // ==========================================
   initial begin
      logic exp_l;
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      check(laser_en, 1'b0);
      check(tx_fault_flag, 1'b0);
      check(light_loss_flag, 1'b1);
      off_lvl = 1'b0;
      wait_for(0, 1'b1, LASER_ON_CYC + 100);
      off_lvl = 1'b1;
      wait_for(0, 1'b0, OFF_CYC);
      off_lvl = 1'b0;
      wait_for(0, 1'b1, ON_CYC);
      $display("test laser on off done");
      fault = 1'b1;
      wait_for(1, 1'b1, FAULT_CYC);
      check(laser_en, 1'b0);
      fault = 1'b0;
      off_lvl = 1'b1;
      // too short a hold must not clear the fault
      repeat (200) @(negedge clock);
      off_lvl = 1'b0;
      repeat (50) @(negedge clock);
      check(tx_fault_flag, 1'b1);
      check(laser_en, 1'b0);
      clear_go = 1'b1;
      @(negedge clock);
      clear_go = 1'b0;
      wait_for(1, 1'b0, RESET_HOLD_CYC + INIT_T);
      wait_for(0, 1'b1, INIT_T);
      $display("test fault latch and clear done");
      exp_l = light_loss_flag;
      for (int i = 0; i < 40; i++) begin
         rng = xs();
         below = rng[0];
         above = rng[1];
         exp_l = exp_loss(rng[0], rng[1], exp_l);
         repeat (20 + rng[5:2]) @(negedge clock);
         check(light_loss_flag, exp_l);
      end
      $display("test light loss done");
      clk_en = 1'b0;
      off_lvl = 1'b1;
      repeat (20) @(negedge clock);
      check(laser_en, 1'b1);
      clk_en = 1'b1;
      wait_for(0, 1'b0, OFF_CYC);
      $display("test clock enable freeze done");
      check(id_clk_too_fast, 1'b0);
      id_mode = 2'h1;
      repeat (SER_MIN_CYC * 3) @(negedge clock);
      check(id_clk_too_fast, 1'b0);
      id_mode = 2'h2;
      repeat (SER_MIN_CYC) @(negedge clock);
      check(id_clk_too_fast, 1'b1);
      $display("test id clock done");
      fault = 1'b1;
      wait_for(1, 1'b1, FAULT_CYC);
      fault = 1'b0;
      rst_n = 1'b0;
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      check(tx_fault_flag, 1'b0);
      check(laser_en, 1'b0);
      check(light_loss_flag, 1'b1);
      repeat (20) @(negedge clock);
      check(tx_fault_flag, 1'b0);
      check(laser_en, 1'b0);
      $display("test power-on reset done");
      end_sim();
   end
endmodule
